/* File: test/mgr_model.sv */
// Station manager model driving the register port
`default_nettype none
module mgr_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  output var logic  [4:0]  addr_o,
  output var logic         wr_o,
  output var logic  [15:0] wdata_o,
  output var logic         rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    {addr_o, wr_o, wdata_o, rd_o} = 23'h000000;
  end
  // One-cycle write strobe, then released data shows a changed word
  task automatic wr(input logic [15:0] d);
    @(negedge clk_i);
    {addr_o, wdata_o, wr_o} = {5'h00, d, 1'b1};
    @(negedge clk_i);
    {wdata_o, wr_o} = {~d, 1'b0};
  endtask : wr
  // One-cycle read strobe, data taken one cycle later
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk_i);
    {addr_o, rd_o} = {a, 1'b1};
    @(negedge clk_i);
    rd_o = 1'b0;
    d = rdata_i;
  endtask : rd
endmodule : mgr_model
`default_nettype wire

/* File: test/phy_regs_monitor.sv */
// Checker of the basic control and status register bank
`default_nettype none
module phy_regs_monitor
  import phy_ctrl_pkg::*;
(
  // Clock, reset and register port
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [4:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // Strap, negotiation and mode
  input wire logic        negotiation_speed_strap_i,
  input wire logic        neg_speed_100_i,
  input wire logic        neg_full_duplex_i,
  input wire logic        soft_reset_o,
  input wire logic        neg_restart_o,
  input wire mode_t       mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Write strobe aimed at the control register
  wire logic cw = reg_wr_i && reg_addr_i == ADDR_BASIC_CONTROL;
  property p_srst; soft_reset_o |-> $past(cw && reg_wdata_i[15]); endproperty
  a_srst: assert property (p_srst) else $error("reset pulse without cause");
  property p_rst_nav; cw && reg_wdata_i[9] && !reg_wdata_i[15] |=> neg_restart_o; endproperty
  a_rst_nav: assert property (p_rst_nav) else $error("restart pulse missing");
  property p_stat; reg_rd_i && reg_addr_i == 5'h01 |=> reg_rdata_o == 16'h6000; endproperty
  a_stat: assert property (p_stat) else $error("status value wrong");
  property p_resv; reg_rd_i && reg_addr_i == 5'h00 |=> reg_rdata_o[6:0] == 7'h00 && reg_rdata_o[15] == 1'b0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero");
  property p_ovr; mode_o.neg_enable && $past(mode_o.neg_enable) && $stable(neg_speed_100_i) |->
    mode_o.speed_100 == neg_speed_100_i; endproperty
  a_ovr: assert property (p_ovr) else $error("negotiated speed not used");
  property p_fld; cw && !reg_wdata_i[15] ##1 !reg_wr_i |=> mode_o.loopback == $past(reg_wdata_i[14], 2)
    && mode_o.isolate == $past(reg_wdata_i[10], 2) && mode_o.col_test == $past(reg_wdata_i[7], 2)
    && mode_o.neg_enable == $past(reg_wdata_i[12], 2); endproperty
  a_fld: assert property (p_fld) else $error("mode fields wrong");
  property p_dflt; soft_reset_o |=> !mode_o.loopback && !mode_o.isolate && !mode_o.power_down; endproperty
  a_dflt: assert property (p_dflt) else $error("defaults not restored");
  property p_strap; soft_reset_o |-> ##2 mode_o.neg_enable == $past(negotiation_speed_strap_i, 2); endproperty
  a_strap: assert property (p_strap) else $error("strap not reloaded");
endmodule : phy_regs_monitor
bind phy_basic_control_status_regs phy_regs_monitor mon (.clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
  .reg_rd_i, .reg_rdata_o, .negotiation_speed_strap_i, .neg_speed_100_i, .neg_full_duplex_i, .soft_reset_o,
  .neg_restart_o, .mode_o);
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking testbench of the basic control and status register bank
`default_nettype none
module testbench;
  import phy_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, reg_wr_i, reg_rd_i, negotiation_speed_strap_i, neg_speed_100_i, neg_full_duplex_i;
  logic soft_reset_o, neg_restart_o;
  logic [4:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, d;
  mode_t mode_o;
  int num_errors = 0, check_count = 0, n_sr = 0, n_rs = 0;
  phy_basic_control_status_regs dut (.clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
    .reg_rdata_o, .negotiation_speed_strap_i, .neg_speed_100_i, .neg_full_duplex_i, .soft_reset_o,
    .neg_restart_o, .mode_o);
  mgr_model mgr (.clk_i, .rdata_i(reg_rdata_o), .addr_o(reg_addr_i), .wr_o(reg_wr_i), .wdata_o(reg_wdata_i),
    .rd_o(reg_rd_i));
  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Count reset and restart pulses
  always @(posedge clk_i) begin
    n_sr += (soft_reset_o === 1'b1);
    n_rs += (neg_restart_o === 1'b1);
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // Watchdog well beyond the few dozen cycles of the tests
  initial begin
    #20000;
    num_errors++;
    results();
  end
  // Test sequence
  initial begin
    {rst_i, negotiation_speed_strap_i, neg_speed_100_i, neg_full_duplex_i} = 4'hc;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    mgr.rd(5'h00, d); chk(d, 16'h3100);
    mgr.wr(16'hffff);
    mgr.rd(5'h01, d); chk(d, 16'h6000);
    mgr.rd(5'h1f, d); chk(d, 16'h0000);
    $display("test reset values done");
    mgr.wr(16'h7fff);
    mgr.rd(5'h00, d); chk(d, 16'h7d80);
    chk({9'h000, mode_o}, 16'h001f);
    chk(n_rs[15:0], 16'h0001);
    {neg_speed_100_i, neg_full_duplex_i} = 2'b11;
    repeat (2) @(negedge clk_i);
    chk({9'h000, mode_o}, 16'h007f);
    mgr.wr(16'h2100);
    mgr.rd(5'h00, d); chk({9'h000, mode_o}, 16'h0060);
    $display("test field writes done");
    mgr.wr(16'h0800);
    mgr.wr(16'h8000);
    mgr.rd(5'h00, d); chk(d, 16'h0000);
    chk(n_sr[15:0], 16'h0001);
    negotiation_speed_strap_i = 1'b0;
    mgr.wr(16'h8000);
    repeat (2) @(negedge clk_i);
    mgr.rd(5'h00, d); chk(d, 16'h0100);
    chk(n_sr[15:0], 16'h0002);
    $display("test power-down exit done");
    results();
  end
endmodule : testbench
`default_nettype wire

/* File: verilog/phy_basic_control_status_regs.sv */
// Basic control and basic status management registers of a 10/100 transceiver
// Notes on behaviour
// - Reset bit write resets device, self-clears
// - Speed bit selects 100/10, ignored when negotiating
// - Negotiation enable bit starts or stops negotiation
// - Negotiated result overrides speed and duplex bits
// - Speed and enable reset from latched strap
// - In power-down, first reset clears; second resets
// - Isolate bit detaches MAC interface, resets zero
// - Restart bit restarts negotiation, then self-clears
// - Collision test bit enables test, resets zero
// - Status 100 full-duplex capability reads one
// - Status 100 half-duplex capability reads one
`default_nettype none
module phy_basic_control_status_regs
  import phy_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Management register port
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // Strap and negotiation result
  input  wire logic        negotiation_speed_strap_i,
  input  wire logic        neg_speed_100_i,
  input  wire logic        neg_full_duplex_i,
  // Mode outputs
  output logic             soft_reset_o,
  output logic             neg_restart_o,
  output mode_t            mode_o
);

  logic       loopback_ff;
  logic       speed_ff;
  logic       neg_en_ff;
  logic       pdown_ff;
  logic       isolate_ff;
  logic       duplex_ff;
  logic       col_test_ff;
  logic       strap_pending_ff;
  logic       wr_ctrl;
  logic       reset_hit;
  logic       do_reset;
  logic [15:0] ctrl_value;

  // Decode of a control register write and the reset bit
  assign wr_ctrl   = reg_wr_i && (reg_addr_i == ADDR_BASIC_CONTROL);
  assign reset_hit = wr_ctrl && reg_wdata_i[BIT_SW_RESET];
  // A reset write in power-down only leaves power-down
  assign do_reset  = reset_hit && !pdown_ff;

  // Strap is latched after release of reset and again on each software reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_pending_ff <= 1'b1;
    end else begin
      strap_pending_ff <= do_reset;
    end
  end

  // Speed and negotiation enable, reset values from the latched strap
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      speed_ff  <= 1'b0;
      neg_en_ff <= 1'b0;
    end else if (strap_pending_ff) begin
      speed_ff  <= negotiation_speed_strap_i;
      neg_en_ff <= negotiation_speed_strap_i;
    end else if (wr_ctrl && !do_reset && !reset_hit) begin
      speed_ff  <= reg_wdata_i[BIT_SPEED_100];
      neg_en_ff <= reg_wdata_i[BIT_NEG_ENABLE];
    end
  end

  // Ordinary read/write control bits; software reset returns them to defaults
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      loopback_ff <= RST_LOOPBACK;
      isolate_ff  <= RST_ISOLATE;
      duplex_ff   <= RST_FULL_DUPLEX;
      col_test_ff <= RST_COL_TEST;
    end else if (do_reset) begin
      loopback_ff <= RST_LOOPBACK;
      isolate_ff  <= RST_ISOLATE;
      duplex_ff   <= RST_FULL_DUPLEX;
      col_test_ff <= RST_COL_TEST;
    end else if (wr_ctrl && !reset_hit) begin
      loopback_ff <= reg_wdata_i[BIT_LOOPBACK];
      isolate_ff  <= reg_wdata_i[BIT_ISOLATE];
      duplex_ff   <= reg_wdata_i[BIT_FULL_DUPLEX];
      col_test_ff <= reg_wdata_i[BIT_COL_TEST];
    end
  end

  // Power-down: first reset write clears it, otherwise written directly
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pdown_ff <= RST_POWER_DOWN;
    end else if (reset_hit) begin
      pdown_ff <= 1'b0;
    end else if (wr_ctrl) begin
      pdown_ff <= reg_wdata_i[BIT_POWER_DOWN];
    end
  end

  // Self-clearing pulses: device reset and negotiation restart
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_reset_o  <= 1'b0;
      neg_restart_o <= 1'b0;
    end else begin
      soft_reset_o  <= do_reset;
      neg_restart_o <= wr_ctrl && !reset_hit && reg_wdata_i[BIT_NEG_RESTART];
    end
  end

  // Control register image; self-clearing and reserved bits read zero
  always_comb begin
    ctrl_value = 16'h0000;
    ctrl_value[BIT_LOOPBACK]    = loopback_ff;
    ctrl_value[BIT_SPEED_100]   = speed_ff;
    ctrl_value[BIT_NEG_ENABLE]  = neg_en_ff;
    ctrl_value[BIT_POWER_DOWN]  = pdown_ff;
    ctrl_value[BIT_ISOLATE]     = isolate_ff;
    ctrl_value[BIT_FULL_DUPLEX] = duplex_ff;
    ctrl_value[BIT_COL_TEST]    = col_test_ff;
  end

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_BASIC_CONTROL: reg_rdata_o <= ctrl_value;
        ADDR_BASIC_STATUS:  reg_rdata_o <= STATUS_VALUE;
        default:            reg_rdata_o <= 16'h0000;
      endcase
    end
  end

  // Effective mode; negotiated speed and duplex win while negotiating
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_o <= '0;
    end else begin
      mode_o.speed_100   <= neg_en_ff ? neg_speed_100_i : speed_ff;
      mode_o.full_duplex <= neg_en_ff ? neg_full_duplex_i : duplex_ff;
      mode_o.loopback    <= loopback_ff;
      mode_o.power_down  <= pdown_ff;
      mode_o.isolate     <= isolate_ff;
      mode_o.col_test    <= col_test_ff;
      mode_o.neg_enable  <= neg_en_ff;
    end
  end

endmodule : phy_basic_control_status_regs
`default_nettype wire

/* File: verilog/phy_ctrl_pkg.sv */
// Package: register map, field positions and reset values of the basic control/status bank
`default_nettype none
package phy_ctrl_pkg;
  localparam logic [4:0]  ADDR_BASIC_CONTROL = 5'h00;
  localparam logic [4:0]  ADDR_BASIC_STATUS  = 5'h01;
  localparam int          BIT_SW_RESET       = 15;
  localparam int          BIT_LOOPBACK       = 14;
  localparam int          BIT_SPEED_100      = 13;
  localparam int          BIT_NEG_ENABLE     = 12;
  localparam int          BIT_POWER_DOWN     = 11;
  localparam int          BIT_ISOLATE        = 10;
  localparam int          BIT_NEG_RESTART    = 9;
  localparam int          BIT_FULL_DUPLEX    = 8;
  localparam int          BIT_COL_TEST       = 7;
  localparam logic        RST_LOOPBACK       = 1'b0;
  localparam logic        RST_POWER_DOWN     = 1'b0;
  localparam logic        RST_ISOLATE        = 1'b0;
  localparam logic        RST_FULL_DUPLEX    = 1'b1;
  localparam logic        RST_COL_TEST       = 1'b0;
  // Upper status bits: T4 reserved zero, 100 full and half capable
  localparam logic [15:0] STATUS_VALUE       = 16'h6000;
  localparam int          RESET_PULSE_CYCLES = 1;

  // Effective operating mode seen by the datapath
  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic loopback;
    logic power_down;
    logic isolate;
    logic col_test;
    logic neg_enable;
  } mode_t;
endpackage : phy_ctrl_pkg
`default_nettype wire
